// ---- verilog/quadrature_encoder_interface.sv ----
// Quadrature encoder interface with prescaler, clear on null and deviation stop
`timescale 1ns/1ps
`default_nettype none
module quadrature_encoder_interface
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic ext_a,
  input wire logic ext_b,
  input wire logic ext_n,
  input wire logic int_a,
  input wire logic int_b,
  input wire logic int_n,
  input wire logic signed [31:0] motor_position,
  input wire logic set_axis_parameter_cmd,
  input wire logic get_axis_parameter_cmd,
  input wire logic [7:0] param_index,
  input wire logic [31:0] param_wdata,
  output logic [31:0] param_rdata,
  output logic param_valid,
  output logic motor_stop,
  output logic deviation_error
);
  import qei_pkg::*;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  logic [31:0] settings_q;
  logic [31:0] max_dev_q;
  logic src_ext_q;
  logic signed [ACC_W-1:0] acc_q;
  logic signed [ACC_W-1:0] acc_d;

  function automatic logic signed [31:0] abs_diff(input logic signed [31:0] x,
                                                  input logic signed [31:0] y);
    logic signed [32:0] d;
    d = 33'(x) - 33'(y);
    if (d < 0) begin
      d = -d;
    end
    abs_diff = (d > 33'sh0_7FFF_FFFF) ? 32'sh7FFF_FFFF : d[31:0];
  endfunction

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      settings_q <= ENC_SETTINGS_RST;
      max_dev_q <= MAX_DEV_RST;
      src_ext_q <= 1'b0;
    end else if (set_axis_parameter_cmd) begin
      if (param_index == PARAM_ENC_SETTINGS) begin
        settings_q <= param_wdata;
      end
      if (param_index == PARAM_MAX_DEVIATION) begin
        max_dev_q <= param_wdata;
      end
      if (param_index == PARAM_ENC_SOURCE) begin
        src_ext_q <= param_wdata[0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // two-stage synchronisers
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {ext_n, ext_b, ext_a, int_n, int_b, int_a};
      sync2_q <= sync1_q;
    end
  end

  // ----------------------------------------------------------------
  // Source select and decode
  // ----------------------------------------------------------------
  logic a_s;
  logic b_s;
  logic n_s;
  assign a_s = src_ext_q ? sync2_q[3] : sync2_q[0];
  assign b_s = src_ext_q ? sync2_q[4] : sync2_q[1];
  assign n_s = src_ext_q ? sync2_q[5] : sync2_q[2];

  logic a_q;
  logic b_q;
  logic src_prev_q;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      a_q <= 1'b0;
      b_q <= 1'b0;
      src_prev_q <= 1'b0;
    end else begin
      a_q <= a_s;
      b_q <= b_s;
      src_prev_q <= src_ext_q;
    end
  end

  step_t step;
  always_comb begin
    step = STEP_NONE;
    if (src_prev_q == src_ext_q) begin
      if (a_s != a_q && b_s == b_q) begin
        step = (a_s != b_s) ? STEP_UP : STEP_DOWN;
      end else if (b_s != b_q && a_s == a_q) begin
        step = (a_s == b_s) ? STEP_UP : STEP_DOWN;
      end
    end
  end

  logic null_hit;
  assign null_hit = (n_s == settings_q[SET_POL_N_BIT])
                    && (a_s == settings_q[SET_POL_A_BIT])
                    && (b_s == settings_q[SET_POL_B_BIT]);

  // ----------------------------------------------------------------
  // Position accumulator
  // ----------------------------------------------------------------
  // prescaler in 1/512 units, function bits masked
  logic signed [ACC_W-1:0] inc;
  assign inc = ACC_W'($signed({1'b0, settings_q[31:5], 5'h00}));

  always_comb begin
    acc_d = acc_q;
    unique case (step)
      STEP_UP: acc_d = acc_q + inc;
      STEP_DOWN: acc_d = acc_q - inc;
      STEP_NONE: acc_d = acc_q;
      default: acc_d = acc_q;
    endcase
    if (settings_q[SET_CLR_NULL_BIT] && null_hit) begin
      acc_d = '0;
    end
    if (set_axis_parameter_cmd && param_index == PARAM_ENC_POSITION) begin
      acc_d = {param_wdata, {PRESCALE_FRAC_BITS{1'b0}}};
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_q <= {ENC_POSITION_RST, {PRESCALE_FRAC_BITS{1'b0}}};
    end else begin
      acc_q <= acc_d;
    end
  end

  logic signed [31:0] enc_pos;
  assign enc_pos = acc_q[ACC_W-1:PRESCALE_FRAC_BITS];

  // ----------------------------------------------------------------
  // Deviation supervision
  // ----------------------------------------------------------------
  logic dev_over;
  // zero disables
  // Unsigned limit: a large limit must not read as negative
  assign dev_over = (max_dev_q != 32'h0000_0000)
                    && ($unsigned(abs_diff(motor_position, enc_pos)) > max_dev_q);

  // stop and flag, cleared by writing encoder position
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      deviation_error <= 1'b0;
      motor_stop <= 1'b0;
    end else if (dev_over) begin
      deviation_error <= 1'b1;
      motor_stop <= 1'b1;
    end else if (set_axis_parameter_cmd && param_index == PARAM_ENC_POSITION) begin
      deviation_error <= 1'b0;
      motor_stop <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Read back
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      param_rdata <= 32'h0000_0000;
      param_valid <= 1'b0;
    end else begin
      param_valid <= get_axis_parameter_cmd;
      if (get_axis_parameter_cmd) begin
        unique case (param_index)
          PARAM_ENC_POSITION: param_rdata <= enc_pos;
          PARAM_ENC_SETTINGS: param_rdata <= settings_q;
          PARAM_MAX_DEVIATION: param_rdata <= max_dev_q;
          PARAM_ENC_SOURCE: param_rdata <= {31'h0, src_ext_q};
          default: param_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  dev_disable_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (max_dev_q == 32'h0 && !$past(dev_over) && $past(max_dev_q) == 32'h0
     && !$past(deviation_error)) |-> !deviation_error)
    else $error("deviation flagged while disabled");
  dev_stop_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    dev_over |=> (motor_stop && deviation_error))
    else $error("deviation did not stop motor");
  pos_write_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (set_axis_parameter_cmd && param_index == PARAM_ENC_POSITION)
    |=> enc_pos == $past(param_wdata))
    else $error("position write lost");
  clr_null_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (settings_q[SET_CLR_NULL_BIT] && null_hit && !set_axis_parameter_cmd)
    |=> acc_q == '0)
    else $error("clear on null missed");
  count_up_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (step == STEP_UP && !set_axis_parameter_cmd
     && !(settings_q[SET_CLR_NULL_BIT] && null_hit))
    |=> acc_q == $past(acc_q) + $past(inc))
    else $error("count up wrong");
  count_dn_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (step == STEP_DOWN && !set_axis_parameter_cmd
     && !(settings_q[SET_CLR_NULL_BIT] && null_hit))
    |=> acc_q == $past(acc_q) - $past(inc))
    else $error("count down wrong");
  src_sel_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    src_ext_q |-> (a_s == sync2_q[3] && b_s == sync2_q[4]))
    else $error("wrong encoder source");
  read_pos_a: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (get_axis_parameter_cmd && param_index == PARAM_ENC_POSITION)
    |=> (param_valid && param_rdata == $past(enc_pos)))
    else $error("position read wrong");

endmodule // quadrature_encoder_interface
`default_nettype wire

// ---- verilog/qei_pkg.sv ----
// Constants and types shared by the quadrature encoder interface
package qei_pkg;

  // ----------------------------------------------------------------
  // Parameter numbers used by the set/get axis parameter commands
  // ----------------------------------------------------------------
  localparam logic [7:0] PARAM_ENC_POSITION = 8'hD1;
  localparam logic [7:0] PARAM_ENC_SETTINGS = 8'hD2;
  localparam logic [7:0] PARAM_MAX_DEVIATION = 8'hD4;
  localparam logic [7:0] PARAM_ENC_SOURCE = 8'h4A;

  // ----------------------------------------------------------------
  // Encoder settings field positions
  // ----------------------------------------------------------------
  localparam int SET_POL_A_BIT = 0;
  localparam int SET_POL_B_BIT = 1;
  localparam int SET_CLR_NULL_BIT = 2;
  localparam int SET_POL_N_BIT = 4;
  localparam int PRESCALE_FRAC_BITS = 9;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] ENC_SETTINGS_RST = 32'h0000_0200;
  localparam logic [31:0] ENC_POSITION_RST = 32'h0000_0000;
  localparam logic [31:0] MAX_DEV_RST = 32'h0000_0000;

  // Accumulator width: position plus fraction bits
  localparam int ACC_W = 32 + PRESCALE_FRAC_BITS;

  typedef enum logic [1:0] {
    STEP_NONE = 2'b00,
    STEP_UP = 2'b01,
    STEP_DOWN = 2'b10
  } step_t;

endpackage

// ---- test/quad_encoder_model.sv ----
// Behavioural incremental quadrature encoder with null channel
`timescale 1ns/1ps
`default_nettype none
module quad_encoder_model (
  output logic a,
  output logic b,
  output logic n
);
  int phase = 0;
  initial begin
    a = 1'b0;
    b = 1'b0;
    n = 1'b0;
  end
  // Gray order 00, 10, 11, 01: only one channel changes per count
  task automatic move(input int steps);
    for (int i = 0; i < (steps < 0 ? -steps : steps); i++) begin
      #250;
      phase = (phase + (steps < 0 ? 3 : 1)) % 4;
      a = (phase == 1) || (phase == 2);
      b = (phase == 2) || (phase == 3);
    end
    #250;
  endtask
  task automatic null_level(input logic lvl);
    n = lvl;
  endtask
endmodule // quad_encoder_model
`default_nettype wire

// ---- test/quadrature_encoder_interface_bench.sv ----
// Self-checking bench for the quadrature encoder interface
`timescale 1ns/1ps
`default_nettype none
module quadrature_encoder_interface_bench;
  import qei_pkg::*;
  logic sys_clk;
  logic rst_n;
  logic set_axis_parameter_cmd;
  logic get_axis_parameter_cmd;
  logic [7:0] param_index;
  logic [31:0] param_wdata;
  logic signed [31:0] motor_position;
  logic [31:0] param_rdata;
  logic param_valid, motor_stop, deviation_error;
  wire logic ext_a, ext_b, ext_n, int_a, int_b, int_n;
  int checks = 0;
  int bad_count = 0;

  quad_encoder_model u_ext (.a(ext_a), .b(ext_b), .n(ext_n));
  quad_encoder_model u_int (.a(int_a), .b(int_b), .n(int_n));
  quadrature_encoder_interface u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .ext_a(ext_a),
    .ext_b(ext_b), .ext_n(ext_n), .int_a(int_a), .int_b(int_b), .int_n(int_n),
    .motor_position(motor_position), .set_axis_parameter_cmd(set_axis_parameter_cmd),
    .get_axis_parameter_cmd(get_axis_parameter_cmd), .param_index(param_index),
    .param_wdata(param_wdata), .param_rdata(param_rdata), .param_valid(param_valid),
    .motor_stop(motor_stop), .deviation_error(deviation_error));

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic close_out();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Samples both status flags mid-cycle, then returns on a rising edge
  task automatic chk_flag(input logic exp);
    @(negedge sys_clk);
    chk({30'h0, motor_stop, deviation_error}, {30'h0, exp, exp});
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    @(posedge sys_clk);
    set_axis_parameter_cmd <= 1'b1;
    param_index <= idx;
    param_wdata <= d;
    @(posedge sys_clk);
    set_axis_parameter_cmd <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    int k;
    @(posedge sys_clk);
    get_axis_parameter_cmd <= 1'b1;
    param_index <= idx;
    @(posedge sys_clk);
    get_axis_parameter_cmd <= 1'b0;
    k = 0;
    @(negedge sys_clk);
    while (param_valid !== 1'b1 && k < 4) begin
      @(negedge sys_clk);
      k++;
    end
    if (k == 4) begin
      bad_count++;
      close_out();
    end else begin
      chk(param_rdata, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  initial begin
    #1000000;
    bad_count++;
    close_out();
  end

  initial begin
    rst_n <= 1'b0;
    set_axis_parameter_cmd <= 1'b0;
    get_axis_parameter_cmd <= 1'b0;
    param_index <= 8'h00;
    param_wdata <= 32'h0000_0000;
    motor_position <= 32'sh0000_0000;
    tick(20);
    rst_n <= 1'b1;
    chk_flag(1'b0);
    rd(PARAM_ENC_SETTINGS, ENC_SETTINGS_RST);
    rd(PARAM_ENC_POSITION, 32'h0000_0000);
    rd(PARAM_MAX_DEVIATION, 32'h0000_0000);
    rd(PARAM_ENC_SOURCE, 32'h0000_0000);
    rd(8'h00, 32'h0000_0000);
    fork
      u_int.move(4);
      u_ext.move(3);
    join
    tick(6);
    rd(PARAM_ENC_POSITION, 32'h0000_0004);
    u_int.move(-2);
    tick(6);
    rd(PARAM_ENC_POSITION, 32'h0000_0002);
    wr(PARAM_ENC_SOURCE, 32'h0000_0001);
    fork
      u_ext.move(5);
      u_int.move(1);
    join
    tick(6);
    rd(PARAM_ENC_POSITION, 32'h0000_0007);
    wr(PARAM_ENC_SOURCE, 32'h0000_0000);
    wr(PARAM_ENC_SETTINGS, 32'h0000_0400);
    u_int.move(-1);
    tick(6);
    rd(PARAM_ENC_POSITION, 32'h0000_0005);
    wr(PARAM_ENC_SETTINGS, 32'h0000_0100);
    u_int.move(2);
    tick(6);
    rd(PARAM_ENC_POSITION, 32'h0000_0006);
    wr(PARAM_ENC_POSITION, 32'h8000_0000);
    rd(PARAM_ENC_POSITION, 32'h8000_0000);
    wr(PARAM_ENC_POSITION, 32'h7FFF_FFFF);
    rd(PARAM_ENC_POSITION, 32'h7FFF_FFFF);
    wr(PARAM_ENC_POSITION, 32'h0000_0003);
    // Clear on null, A, B and null all active high
    wr(PARAM_ENC_SETTINGS, 32'h0000_0217);
    // Unselected encoder's null must not clear
    u_ext.null_level(1'b1);
    u_int.move(2);
    tick(6);
    rd(PARAM_ENC_POSITION, 32'h0000_0005);
    u_int.null_level(1'b1);
    tick(6);
    rd(PARAM_ENC_POSITION, 32'h0000_0000);
    u_int.null_level(1'b0);
    u_ext.null_level(1'b0);
    wr(PARAM_ENC_SETTINGS, ENC_SETTINGS_RST);
    wr(PARAM_ENC_POSITION, 32'h0000_000A);
    wr(PARAM_MAX_DEVIATION, 32'h0000_0005);
    motor_position <= 32'sh0000_000F;
    tick(3);
    chk_flag(1'b0);
    motor_position <= 32'sh0000_0010;
    tick(3);
    chk_flag(1'b1);
    // First write still meets the old deviation, so the flag stays
    wr(PARAM_ENC_POSITION, 32'h0000_0010);
    tick(3);
    chk_flag(1'b1);
    wr(PARAM_ENC_POSITION, 32'h0000_0010);
    tick(3);
    chk_flag(1'b0);
    // Limit with top bit set is a large limit, not a negative one
    wr(PARAM_MAX_DEVIATION, 32'h8000_0000);
    motor_position <= 32'sh0000_03E8;
    tick(3);
    chk_flag(1'b0);
    wr(PARAM_MAX_DEVIATION, 32'h0000_0000);
    motor_position <= 32'sh0010_0000;
    tick(3);
    chk_flag(1'b0);
    close_out();
  end
endmodule // quadrature_encoder_interface_bench
`default_nettype wire
